/* mdi_input_logic.sv */
// Purpose: input-side command logic of a brushless motor driver
// Assumes: terminals are asynchronous pins; MOTOR_STOPPED is on CLK_SYS
// Notes:   control, polarity and status registers on a plain port;
//          commands leave as registered levels for the motor core;
//          data selection has no strobe, it is sampled every cycle
`timescale 1ns/100ps

module mdi_input_logic
    import mdi_pkg::*;
(
    input wire logic CLK_SYS,                  // 100 MHz system clock
    input wire logic RESETN,                   // async reset, active low
    input wire logic [8:0] INPUT_TERMINAL,     // isolator outputs, 1=current
    input wire logic MOTOR_STOPPED,            // motor core: shaft at rest
    input wire logic [7:0] REG_ADDR,           // register byte address
    input wire logic [31:0] REG_WDATA,         // register write data
    input wire logic REG_WR,                   // write strobe
    input wire logic REG_RD,                   // read strobe
    output logic [31:0] REG_RDATA,             // read data, cycle after
    output logic RUN_CMD,                      // rotate at selected speed
    output logic DECEL_CMD,                    // decelerate to a stop
    output logic RUN_CW,                       // shaft direction, 1=cw
    output logic [3:0] DATA_NUMBER,            // selected operation data
    output logic EXCITE,                       // motor current enabled
    output logic BRAKE_RELEASE                 // 1 releases the brake
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    // synchroniser and corrected levels
    logic [N_TERM-1:0] sync1_q;
    logic [N_TERM-1:0] sync2_q;
    logic [N_TERM-1:0] level;
    // configuration and read data
    logic [CTRL_W-1:0] ctrl_q;
    logic [N_TERM-1:0] pol_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    // motion state and registered commands
    mdi_state_t state_q;
    mdi_state_t state_d;
    logic run_pos_q;      // request being served was forward
    logic run_pos_d;
    logic run_q;
    logic decel_q;
    logic cw_q;
    logic [3:0] num_q;
    logic excite_q;
    logic brake_q;

    // decode and select wires
    wire logic forward_run_request;
    wire logic reverse_run_request;
    wire logic coast;
    wire logic [3:0] sel_num;
    wire logic pos_mode;
    wire logic dir_cw;
    wire logic servo_lock;
    wire logic brake_fitted;
    wire logic one_req;
    wire logic req_pos;
    wire logic same_req;
    wire logic excite_d;
    wire logic brake_d;
    wire logic cw_d;
    wire logic run_d;
    wire logic decel_d;
    wire logic wr_ctrl;
    wire logic wr_pol;
    wire logic rd_ctrl;
    wire logic rd_pol;
    wire logic rd_stat;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // input capture: two flops per pin, then polarity
    // current means asserted
    // the isolator output is already high while current flows
    // only the second flop is read: the first may still be settling
    // after a pin edge that lands close to the clock
    genvar gi;
    generate
        for (gi = 0; gi < N_TERM; gi++) begin : g_term
            // flops reset low: no current, the level of a loose pin
            always_ff @(posedge CLK_SYS or negedge RESETN) begin
                if (!RESETN) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= INPUT_TERMINAL[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
            assign level[gi] = sync2_q[gi] ^ pol_q[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // functional decode of corrected levels
    // no extra debounce: the controller holds each level for 10 ms,
    // so a glitch shorter than that is not guarded against here
    // relies on long holds
    assign forward_run_request = level[TERM_FWD];
    assign reverse_run_request = level[TERM_RVS];
    assign coast = level[TERM_COAST];
    assign sel_num = level[TERM_SEL0 +: 4];

    // configuration fields
    // a mode change while moving is not blocked: stop the motor first
    assign pos_mode = ctrl_q[CTRL_MODE_BIT];
    assign dir_cw = ctrl_q[CTRL_DIR_BIT];
    assign servo_lock = ctrl_q[CTRL_LOCK_BIT];
    assign brake_fitted = ctrl_q[CTRL_BRAKE_BIT];

    // request classification; the served direction is kept so that a
    // swap of pins ends the run instead of counting as a re-request
    // (see decel below)
    // both or neither is no request
    assign one_req = forward_run_request ^ reverse_run_request;
    assign req_pos = forward_run_request;
    assign same_req = one_req && (req_pos == run_pos_q);

    ////////////////////////////////////////////////////////////////////////
    // motion state machine
    // idle  : no motion; a lone request starts a run
    // run   : the served request, still alone, keeps it running
    // decel : ramp down until the motor core reports rest; the same
    //         request alone again resumes the run
    // coast : current off, entered from any state while coast is up
    // swapping one pin for the other passes through decel to rest
    // speed and position modes share these moves; they differ only
    // in whether the motor stays excited at rest
    always_comb begin
        state_d = state_q;
        run_pos_d = run_pos_q;
        unique case (state_q)
            ST_IDLE: begin
                if (one_req) begin
                    state_d = ST_RUN;
                    run_pos_d = req_pos;
                end
            end
            ST_RUN: begin
                if (!same_req) begin
                    state_d = ST_DECEL;
                end
            end
            ST_DECEL: begin
                // rest comes from the motor core on this clock; a rest
                // signal from a pin would need its own synchroniser
                // same request re-accelerates
                if (same_req) begin
                    state_d = ST_RUN;
                end else if (MOTOR_STOPPED) begin
                    state_d = ST_IDLE;
                end
            end
            ST_COAST: begin
                // leave to idle so a held request starts afresh
                if (!coast) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
        // coast is looked at last so that it wins over every move above
        // coast overrides requests
        if (coast) begin
            state_d = ST_COAST;
        end
    end

    // direction follows the next served request, so it settles in the
    // same cycle as the run command rises
    // positive direction mapping
    assign cw_d = run_pos_d ? dir_cw : !dir_cw;

    ////////////////////////////////////////////////////////////////////////
    // excitation: on while moving; at rest only with servo lock in speed
    // mode; position mode always holds position at rest
    // speed mode without servo lock leaves the shaft free at rest,
    // trading holding torque for a motor that runs cool when parked
    // coast cuts current
    assign excite_d = (state_d == ST_RUN) || (state_d == ST_DECEL) ||
                      ((state_d == ST_IDLE) && (pos_mode || servo_lock));

    // brake released while excited, or by coast on a braked motor
    // coast releases brake
    assign brake_d = excite_d || (state_d == ST_COAST && brake_fitted);

    // command decode of the next state
    assign run_d = (state_d == ST_RUN);
    assign decel_d = (state_d == ST_DECEL);

    ////////////////////////////////////////////////////////////////////////
    // state registers; run_pos resets to forward, which only matters
    // until the first request is served
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            run_pos_q <= 1'b1;
        end else begin
            state_q <= state_d;
            run_pos_q <= run_pos_d;
        end
    end

    // motion commands, registered so that the motor core never sees
    // the next-state logic settle
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            run_q <= 1'b0;
            decel_q <= 1'b0;
            cw_q <= 1'b0;
        end else begin
            run_q <= run_d;
            decel_q <= decel_d;
            cw_q <= cw_d;
        end
    end

    // excitation and brake; one decision cycle after the synchroniser,
    // far inside the 10 ms excitation window
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            excite_q <= 1'b0;
            brake_q <= 1'b0;
        end else begin
            excite_q <= excite_d;
            brake_q <= brake_d;
        end
    end

    // data number follows the corrected select bits every cycle; a
    // change while running switches the selected speed at once
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            num_q <= 4'h0;
        end else begin
            num_q <= sel_num;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port: decode; writes to any other address are dropped,
    // and the status word is read only
    assign wr_ctrl = REG_WR && (REG_ADDR == OFS_CTRL);
    assign wr_pol = REG_WR && (REG_ADDR == OFS_POLARITY);
    assign rd_ctrl = REG_RD && (REG_ADDR == OFS_CTRL);
    assign rd_pol = REG_RD && (REG_ADDR == OFS_POLARITY);
    assign rd_stat = REG_RD && (REG_ADDR == OFS_STATUS);

    // status word shows the block's own state; fields sit at the
    // package positions so software and logic share one map
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_LEVEL_LSB +: N_TERM] = level;
        status_word[STAT_NUM_LSB +: 4] = num_q;
        status_word[STAT_STATE_LSB +: 2] = state_q;
        status_word[STAT_EXCITE_BIT] = excite_q;
        status_word[STAT_BRAKE_BIT] = brake_q;
        status_word[STAT_CW_BIT] = cw_q;
    end

    // read mux; unmapped addresses and idle cycles read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_ctrl) begin
            rdata_d = {28'h000_0000, ctrl_q};
        end else if (rd_pol) begin
            rdata_d = {23'h00_0000, pol_q};
        end else if (rd_stat) begin
            rdata_d = status_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= REG_WDATA[CTRL_W-1:0];
        end
    end

    // polarity register; a write flips the corrected levels at once,
    // so software should change it only with the motor stopped
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pol_q <= POLARITY_RESET;
        end else if (wr_pol) begin
            pol_q <= REG_WDATA[N_TERM-1:0];
        end
    end

    // read data stand only in the cycle after the strobe and fall back
    // to zero, so a stale word never lingers on the port
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    // no decode glitch can reach the motor core or the register port
    assign REG_RDATA = rdata_q;
    assign RUN_CMD = run_q;
    assign DECEL_CMD = decel_q;
    assign RUN_CW = cw_q;
    assign DATA_NUMBER = num_q;
    assign EXCITE = excite_q;
    assign BRAKE_RELEASE = brake_q;

endmodule : mdi_input_logic

/* mdi_pkg.sv */
// Purpose: shared constants for the motor driver input logic
// Assumes: 100 MHz system clock, 32-bit plain register port
// Notes:   byte offsets, field positions and reset values live here only
package mdi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // terminal count and terminal-to-function assignment
    localparam int unsigned N_TERM = 9;
    localparam int unsigned TERM_FWD = 0;   // forward run request
    localparam int unsigned TERM_RVS = 1;   // reverse run request
    localparam int unsigned TERM_SEL0 = 2;  // data select bit0..bit3
    localparam int unsigned TERM_COAST = 6; // coast (current cut-off)

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POLARITY = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // control register fields
    localparam int unsigned CTRL_MODE_BIT = 0;    // 0 speed, 1 position
    localparam int unsigned CTRL_DIR_BIT = 1;     // 1: positive is cw
    localparam int unsigned CTRL_LOCK_BIT = 2;    // 1: servo lock
    localparam int unsigned CTRL_BRAKE_BIT = 3;   // 1: brake fitted
    localparam int unsigned CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'ha;     // dir=1, brake fitted

    // polarity register reset: every terminal passes unchanged
    localparam logic [8:0] POLARITY_RESET = 9'h000;

    // status register fields
    localparam int unsigned STAT_LEVEL_LSB = 0;   // 9 corrected levels
    localparam int unsigned STAT_NUM_LSB = 12;    // data number
    localparam int unsigned STAT_STATE_LSB = 16;  // 2-bit motion state
    localparam int unsigned STAT_EXCITE_BIT = 18;
    localparam int unsigned STAT_BRAKE_BIT = 19;
    localparam int unsigned STAT_CW_BIT = 20;

    // motion states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DECEL,
        ST_COAST
    } mdi_state_t;

endpackage : mdi_pkg

/* mdi_input_logic_asserts.sv */
// Purpose: port checker for the motor driver input logic
// Assumes: pins held a few cycles between changes
// Notes: mirrors ctrl and polarity writes to rebuild levels
`timescale 1ns/100ps
module mdi_input_logic_asserts
    import mdi_pkg::*;
(
    input wire logic CLK_SYS, // clock
    input wire logic RESETN, // reset
    input wire logic [8:0] INPUT_TERMINAL, // pins
    input wire logic MOTOR_STOPPED, // at rest
    input wire logic [7:0] REG_ADDR, // address
    input wire logic [31:0] REG_WDATA, // wdata
    input wire logic REG_WR, // write
    input wire logic REG_RD, // read
    input wire logic [31:0] REG_RDATA, // rdata
    input wire logic RUN_CMD, // run
    input wire logic DECEL_CMD, // decel
    input wire logic RUN_CW, // cw
    input wire logic [3:0] DATA_NUMBER, // number
    input wire logic EXCITE, // current on
    input wire logic BRAKE_RELEASE // brake off
);
    logic [8:0] pol_q, c1_q, c2_q, c3_q;
    logic [3:0] ctl_q;
    logic [2:0] age_q;
    // checks wait 7 cycles after a write, the pipes differ then
    wire settled = age_q == 3'h7;
    wire alone = c3_q[0] ^ c3_q[1];
    // mirror of writable state, pipelined like the terminals
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            {pol_q, c1_q, c2_q, c3_q} <= 36'h0;
            ctl_q <= CTRL_RESET;
            age_q <= 3'h0;
        end else begin
            c1_q <= INPUT_TERMINAL ^ pol_q;
            {c3_q, c2_q} <= {c2_q, c1_q};
            age_q <= REG_WR ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
            if (REG_WR && REG_ADDR == OFS_POLARITY)
                pol_q <= REG_WDATA[8:0];
            if (REG_WR && REG_ADDR == OFS_CTRL)
                ctl_q <= REG_WDATA[3:0];
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    sequence s_coast; settled && c3_q[6]; endsequence
    sequence s_req;
        settled && alone && !c3_q[6] && !$past(c3_q[6])
            && !$past(DECEL_CMD) && !DECEL_CMD;
    endsequence
    sequence s_stop;
        settled && DECEL_CMD && MOTOR_STOPPED && c2_q[1:0] == 2'h0;
    endsequence
    property p_num; settled |-> DATA_NUMBER == c3_q[5:2]; endproperty
    a_num: assert property (p_num)
        else $error("data number wrong");
    property p_coast; s_coast |-> !RUN_CMD && !DECEL_CMD && !EXCITE;
    endproperty
    a_coast: assert property (p_coast)
        else $error("coast left motion on");
    property p_brake; s_coast |-> BRAKE_RELEASE == ctl_q[3]; endproperty
    a_brake: assert property (p_brake)
        else $error("brake wrong in coast");
    property p_dir;
        settled && RUN_CMD |-> RUN_CW == (c3_q[0] ? ctl_q[1] : !ctl_q[1]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction wrong");
    property p_pair; settled && !alone |-> !RUN_CMD; endproperty
    a_pair: assert property (p_pair)
        else $error("run without a lone request");
    property p_fell; settled && $fell(RUN_CMD) && !c3_q[6] |-> DECEL_CMD;
    endproperty
    a_fell: assert property (p_fell)
        else $error("run ended without decel");
    property p_stop; s_stop |=> !DECEL_CMD && !RUN_CMD; endproperty
    a_stop: assert property (p_stop)
        else $error("decel kept after stop");
    property p_run; s_req |-> RUN_CMD && EXCITE && BRAKE_RELEASE;
    endproperty
    a_run: assert property (p_run)
        else $error("lone request did not run");
    property p_idle;
        settled && !c3_q[6] && !RUN_CMD && !DECEL_CMD
            |-> EXCITE == (ctl_q[0] | ctl_q[2]);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle excitation wrong");
endmodule : mdi_input_logic_asserts
bind mdi_input_logic mdi_input_logic_asserts u_asserts (.CLK_SYS(CLK_SYS),
    .RESETN(RESETN), .INPUT_TERMINAL(INPUT_TERMINAL), .REG_RD(REG_RD),
    .MOTOR_STOPPED(MOTOR_STOPPED), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .RUN_CMD(RUN_CMD),
    .DECEL_CMD(DECEL_CMD), .RUN_CW(RUN_CW), .DATA_NUMBER(DATA_NUMBER),
    .EXCITE(EXCITE), .BRAKE_RELEASE(BRAKE_RELEASE));

/* mdi_ctrl_model.sv */
// Purpose: controller and motor model at the terminals
// Assumes: wanted levels come from the bench
// Notes: shaft stops a fixed time into deceleration
`timescale 1ns/100ps
module mdi_ctrl_model #(
    parameter int STOP_CYC = 12
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic [8:0] req, // wanted levels
    input wire logic run, // motor running
    input wire logic decel, // motor decelerating
    output logic [8:0] term, // terminal pins
    output logic stopped // shaft at rest
);
    logic [3:0] cnt_q;
    // levels held
    // 1 means current flows; held far longer than the 3-cycle path
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            term <= 9'h000;
        else
            term <= req;
    end
    // shaft coasts down for STOP_CYC cycles once decel starts
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || !decel)
            cnt_q <= 4'h0;
        else if (cnt_q != STOP_CYC)
            cnt_q <= cnt_q + 4'h1;
    end
    assign stopped = !run && (!decel || cnt_q == STOP_CYC);
endmodule : mdi_ctrl_model

/* mdi_input_logic_tb.sv */
// Purpose: self-checking bench for the motor driver input logic
// Assumes: 100 MHz clock, controller model on the terminals
// Notes: pins reach the outputs four edges after a request
`timescale 1ns/100ps
module mdi_input_logic_tb
    import mdi_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [8:0] req = 9'h000, term;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic stopped, run, decel, cw, exc, brk;
    logic [3:0] num;
    int failures = 0, num_checks = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    mdi_ctrl_model u_model (.clk(clk), .rst_n(rst_n), .req(req), .run(run),
        .decel(decel), .term(term), .stopped(stopped));
    mdi_input_logic u_dut (.CLK_SYS(clk), .RESETN(rst_n), .REG_RD(rd_s),
        .INPUT_TERMINAL(term), .MOTOR_STOPPED(stopped), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RDATA(rdata), .RUN_CMD(run),
        .DECEL_CMD(decel), .RUN_CW(cw), .DATA_NUMBER(num), .EXCITE(exc),
        .BRAKE_RELEASE(brk));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic exp_cw(input logic forward_run_request, input logic dir);
        return forward_run_request ? dir : !dir;
    endfunction : exp_cw
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wdata, wr_s} <= {a, d, 1'b1};
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {addr, rd_s} <= {a, 1'b1};
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task pins(input logic [8:0] v);
        @(posedge clk);
        req <= v;
        repeat (5) @(posedge clk);
        #1;
    endtask : pins
    task wait_idle;
        int i;
        for (i = 0; i < 40 && decel !== 1'b0; i++) @(posedge clk) #1;
        if (i == 40) begin
            failures++;
            $display("mismatch at %0t: no return to idle", $time);
            complete_run();
        end
    endtask : wait_idle
    task complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [8:0] p, v;
        void'($urandom(76));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, then an unmapped place
        rd(OFS_CTRL, d);
        chk(d, {28'h0, CTRL_RESET});
        rd(OFS_POLARITY, d);
        chk(d, 32'h0);
        rd(8'h10, d);
        chk(d, 32'h0);
        for (int n = 0; n < 16; n++) begin
            pins({3'h0, n[3:0], 2'h0});
            chk(num, n[3:0]);
        end
        // random polarity over random select levels
        for (int k = 0; k < 8; k++) begin
            p = 9'($urandom);
            v = 9'($urandom) & 9'h03c;
            wr(OFS_POLARITY, {23'h0, p});
            pins(v);
            rd(OFS_STATUS, d);
            chk(d[8:0], v ^ p);
            chk(num, (v[5:2] ^ p[5:2]));
        end
        wr(OFS_POLARITY, 32'h0);
        pins(9'h000);
        wait_idle();
        $display("test select done");
        // each mode and direction: run, both, re-request, release
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, {28'h0, 2'h2, m[1], m[0]});
            for (int f = 0; f < 2; f++) begin
                pins(f ? 9'h001 : 9'h002);
                chk({run, exc, cw}, {2'h3, exp_cw(f[0], m[1])});
                pins(9'h003);
                chk({run, decel}, 2'h1);
                pins(f ? 9'h001 : 9'h002);
                chk(run, 1'b1);
                pins(9'h000);
                chk(decel, 1'b1);
                wait_idle();
                chk(exc, m[0]);
            end
        end
        $display("test motion done");
        // servo lock holds, coast cuts current with and without brake
        wr(OFS_CTRL, 32'h0000000c);
        pins(9'h000);
        chk(exc, 1'b1);
        pins(9'h001);
        pins(9'h041);
        chk({run, decel, exc, brk}, 4'h1);
        wr(OFS_CTRL, 32'h00000001);
        pins(9'h041);
        chk({run, exc, brk}, 3'h0);
        pins(9'h001);
        chk({run, exc}, 2'h3);
        wr(OFS_POLARITY, 32'h00000040);
        pins(9'h001);
        chk({run, exc}, 2'h0);
        $display("test coast done");
        complete_run();
    end
endmodule : mdi_input_logic_tb
